//--- hdl/ppdc_apb_regs.sv
// apb slave front end: decodes one access into a register select and strobes
`timescale 1ns/1ns
module ppdc_apb_regs
    import ppdc_pkg::*;
(
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PPDC_ADDR_W-1:0] paddr,
    output logic [5:0] sel_onehot,
    output logic hit,
    output logic wr_stb,
    output logic rd_stb
);
    logic [9:0] idx;
    logic aligned;

    // ==========================================================
    // decode
    assign idx = paddr[PPDC_ADDR_W-1:2];
    assign aligned = (paddr[1:0] == 2'b00);
    assign sel_onehot[0] = aligned && (idx == PPDC_IDX_PULLUP_ENABLE_0);
    assign sel_onehot[1] = aligned && (idx == PPDC_IDX_PULLUP_ENABLE_1);
    assign sel_onehot[2] = aligned && (idx == PPDC_IDX_PORT1_DRIVE_STRENGTH);
    assign sel_onehot[3] = aligned && (idx == PPDC_IDX_PORT2_DRIVE_STRENGTH);
    assign sel_onehot[4] = aligned && (idx == PPDC_IDX_GROUP_DRIVE_STRENGTH_0);
    assign sel_onehot[5] = aligned && (idx == PPDC_IDX_GROUP_DRIVE_STRENGTH_1);
    assign hit = |sel_onehot;
    // access phase only; slave is zero-wait so the access completes here
    assign wr_stb = psel && penable && pwrite;
    assign rd_stb = psel && penable && !pwrite;
endmodule : ppdc_apb_regs

//--- hdl/ppdc_pad_gate.sv
// per-pin gating of pull-up and drive selections by the port direction
`timescale 1ns/1ns
module ppdc_pad_gate #(
    parameter int PINS = 8
) (
    input wire logic [PINS-1:0] pull_sel,
    input wire logic [PINS-1:0] drive_sel,
    input wire logic [PINS-1:0] dir_out,
    output logic [PINS-1:0] pull_en,
    output logic [PINS-1:0] drive_hi
);
    // elaboration-time refusal of a width the gating cannot serve
    if (PINS < 1) begin : g_bad_pins
        $error("ppdc_pad_gate: PINS must be at least 1");
    end

    // ==========================================================
    // gating
    for (genvar i = 0; i < PINS; i++) begin : g_pin
        assign pull_en[i] = pull_sel[i] & ~dir_out[i];
        // one enable for both output levels, pad drives high and low strong
        assign drive_hi[i] = drive_sel[i] & dir_out[i];
    end
endmodule : ppdc_pad_gate

//--- hdl/ppdc_pkg.sv
// package with the register map and field layout of the pad pull-up and drive control bank
package ppdc_pkg;
    // ==========================================================
    // register map: printed offsets are not all multiples of four,
    // so these are register indices and the byte address is four times the index
    localparam logic [9:0] PPDC_IDX_PULLUP_ENABLE_0 = 10'h1E0;
    localparam logic [9:0] PPDC_IDX_PULLUP_ENABLE_1 = 10'h1E1;
    localparam logic [9:0] PPDC_IDX_PORT1_DRIVE_STRENGTH = 10'h1F0;
    localparam logic [9:0] PPDC_IDX_PORT2_DRIVE_STRENGTH = 10'h1F1;
    localparam logic [9:0] PPDC_IDX_GROUP_DRIVE_STRENGTH_0 = 10'h1F2;
    localparam logic [9:0] PPDC_IDX_GROUP_DRIVE_STRENGTH_1 = 10'h1F3;
    localparam int PPDC_ADDR_W = 12;

    // ==========================================================
    // writable bit masks per register
    localparam logic [7:0] PPDC_MASK_PULLUP_ENABLE_0 = 8'hFF;
    localparam logic [7:0] PPDC_MASK_PULLUP_ENABLE_1 = 8'hFF;
    localparam logic [7:0] PPDC_MASK_PORT1_DRIVE_STRENGTH = 8'hFF;
    localparam logic [7:0] PPDC_MASK_PORT2_DRIVE_STRENGTH = 8'hFF;
    localparam logic [7:0] PPDC_MASK_GROUP_DRIVE_STRENGTH_0 = 8'hC3;
    localparam logic [7:0] PPDC_MASK_GROUP_DRIVE_STRENGTH_1 = 8'h3B;
    // bits of pullup_enable_1 with no function, read back as undefined
    localparam logic [7:0] PPDC_UNDEF_PULLUP_ENABLE_1 = 8'hC0;

    // ==========================================================
    // reset values
    localparam logic [7:0] PPDC_RESET_VALUE = 8'h00;

    // ==========================================================
    // field positions
    localparam int PPDC_PU1_PORT4_PIN3 = 0;
    localparam int PPDC_PU1_PORT4_UPPER = 1;
    localparam int PPDC_PU1_PORT6_PIN6 = 5;
    localparam int PPDC_DR0_PORT0_LOW = 0;
    localparam int PPDC_DR0_PORT0_HIGH = 1;
    localparam int PPDC_DR0_PORT3_LOW = 6;
    localparam int PPDC_DR0_PORT3_HIGH = 7;
    localparam int PPDC_DR1_PORT4_PIN3 = 0;
    localparam int PPDC_DR1_PORT4_UPPER = 1;
    localparam int PPDC_DR1_PORT6_PIN6 = 5;

    // ==========================================================
    // pin-to-group maps: one byte per group or pin mask, bit set where the pin is served
    localparam logic [7:0] PPDC_P0_GRP_LOW = 8'h0E;
    localparam logic [7:0] PPDC_P0_GRP_HIGH = 8'hD0;
    localparam logic [7:0] PPDC_P1_GRP_LOW = 8'h0F;
    localparam logic [7:0] PPDC_P1_GRP_HIGH = 8'hF0;
    localparam logic [7:0] PPDC_P2_GRP_LOW = 8'h0F;
    localparam logic [7:0] PPDC_P2_GRP_HIGH = 8'h30;
    localparam logic [7:0] PPDC_P2_PINS = 8'h3F;
    localparam logic [7:0] PPDC_P3_GRP_LOW = 8'h0A;
    localparam logic [7:0] PPDC_P3_GRP_HIGH = 8'hB0;
    localparam logic [7:0] PPDC_P4_PIN3 = 8'h08;
    localparam logic [7:0] PPDC_P4_UPPER = 8'hF0;
    localparam logic [7:0] PPDC_P6_PIN6 = 8'h40;
endpackage : ppdc_pkg

//--- hdl/ppdc_top.sv
// pad pull-up and drive strength control register bank with apb access
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ns
module ppdc_top
    import ppdc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PPDC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] port0_dir,
    input wire logic [7:0] port1_dir,
    input wire logic [7:0] port2_dir,
    input wire logic [7:0] port3_dir,
    input wire logic [7:0] port4_dir,
    input wire logic [7:0] port6_dir,
    output logic [7:0] port0_pull_en,
    output logic [7:0] port1_pull_en,
    output logic [7:0] port2_pull_en,
    output logic [7:0] port3_pull_en,
    output logic [7:0] port4_pull_en,
    output logic [7:0] port6_pull_en,
    output logic [7:0] port0_drive_hi,
    output logic [7:0] port1_drive_hi,
    output logic [7:0] port2_drive_hi,
    output logic [7:0] port3_drive_hi,
    output logic [7:0] port4_drive_hi,
    output logic [7:0] port6_drive_hi
);
    localparam int NPORT = 6;

    logic [7:0] pullup_enable_0_reg;
    logic [7:0] pullup_enable_1_reg;
    logic [7:0] port1_drive_strength_reg;
    logic [7:0] port2_drive_strength_reg;
    logic [7:0] group_drive_strength_0_reg;
    logic [7:0] group_drive_strength_1_reg;
    logic [7:0] undef_bits_reg;
    logic [5:0] sel_onehot;
    logic hit;
    logic wr_stb;
    logic wr_lane0;
    logic [7:0] rd_byte;
    logic [7:0] dir_sync1_reg [NPORT];
    logic [7:0] dir_sync2_reg [NPORT];
    logic [7:0] dir_in [NPORT];
    logic [7:0] pull_sel [NPORT];
    logic [7:0] drive_sel [NPORT];
    logic [7:0] pull_en_next [NPORT];
    logic [7:0] drive_hi_next [NPORT];
    logic [7:0] pull_en_reg [NPORT];
    logic [7:0] drive_hi_reg [NPORT];

    // ==========================================================
    // apb decode
    ppdc_apb_regs u_apb (
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .sel_onehot(sel_onehot),
        .hit(hit),
        .wr_stb(wr_stb),
        .rd_stb()
    );

    // narrow registers live in byte lane 0; other lanes are dropped
    assign wr_lane0 = wr_stb && hit && pstrb[0];

    // ==========================================================
    // register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pullup_enable_0_reg <= PPDC_RESET_VALUE;
            pullup_enable_1_reg <= PPDC_RESET_VALUE;
            port1_drive_strength_reg <= PPDC_RESET_VALUE;
            port2_drive_strength_reg <= PPDC_RESET_VALUE;
            group_drive_strength_0_reg <= PPDC_RESET_VALUE;
            group_drive_strength_1_reg <= PPDC_RESET_VALUE;
        end else if (wr_lane0) begin
            if (sel_onehot[0]) begin
                pullup_enable_0_reg <= pwdata[7:0] & PPDC_MASK_PULLUP_ENABLE_0;
            end
            if (sel_onehot[1]) begin
                pullup_enable_1_reg <= pwdata[7:0] & PPDC_MASK_PULLUP_ENABLE_1;
            end
            if (sel_onehot[2]) begin
                port1_drive_strength_reg <= pwdata[7:0] & PPDC_MASK_PORT1_DRIVE_STRENGTH;
            end
            if (sel_onehot[3]) begin
                // reserved bits stored as written; software keeps them zero
                port2_drive_strength_reg <= pwdata[7:0] & PPDC_MASK_PORT2_DRIVE_STRENGTH;
            end
            if (sel_onehot[4]) begin
                group_drive_strength_0_reg <= pwdata[7:0] & PPDC_MASK_GROUP_DRIVE_STRENGTH_0;
            end
            if (sel_onehot[5]) begin
                group_drive_strength_1_reg <= pwdata[7:0] & PPDC_MASK_GROUP_DRIVE_STRENGTH_1;
            end
        end
    end

    // ==========================================================
    // undefined read bits: a free toggling pattern, so nothing can rely on them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            undef_bits_reg <= PPDC_RESET_VALUE;
        end else begin
            undef_bits_reg <= ~undef_bits_reg;
        end
    end

    // ==========================================================
    // read mux
    always_comb begin
        rd_byte = 8'h00;
        unique case (1'b1)
            sel_onehot[0]: rd_byte = pullup_enable_0_reg;
            sel_onehot[1]: rd_byte = (pullup_enable_1_reg & ~PPDC_UNDEF_PULLUP_ENABLE_1)
                | (undef_bits_reg & PPDC_UNDEF_PULLUP_ENABLE_1);
            sel_onehot[2]: rd_byte = port1_drive_strength_reg;
            sel_onehot[3]: rd_byte = port2_drive_strength_reg;
            sel_onehot[4]: rd_byte = group_drive_strength_0_reg;
            sel_onehot[5]: rd_byte = group_drive_strength_1_reg;
            default: rd_byte = 8'h00;
        endcase
    end

    // ==========================================================
    // apb response: no wait state, data and ready both from flops loaded in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            pready <= 1'b1;
            pslverr <= !hit;
            prdata <= (!pwrite && hit) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
    end

    // ==========================================================
    // direction inputs come from another block's pins, so synchronise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int p = 0; p < NPORT; p++) begin
                dir_sync1_reg[p] <= 8'h00;
                dir_sync2_reg[p] <= 8'h00;
            end
        end else begin
            dir_sync1_reg[0] <= port0_dir;
            dir_sync1_reg[1] <= port1_dir;
            dir_sync1_reg[2] <= port2_dir;
            dir_sync1_reg[3] <= port3_dir;
            dir_sync1_reg[4] <= port4_dir;
            dir_sync1_reg[5] <= port6_dir;
            for (int p = 0; p < NPORT; p++) begin
                dir_sync2_reg[p] <= dir_sync1_reg[p];
            end
        end
    end
    assign dir_in = dir_sync2_reg;

    // ==========================================================
    // register bits spread onto pins
    always_comb begin
        pull_sel[0] = ({8{pullup_enable_0_reg[0]}} & PPDC_P0_GRP_LOW)
            | ({8{pullup_enable_0_reg[1]}} & PPDC_P0_GRP_HIGH);
        pull_sel[1] = ({8{pullup_enable_0_reg[2]}} & PPDC_P1_GRP_LOW)
            | ({8{pullup_enable_0_reg[3]}} & PPDC_P1_GRP_HIGH);
        pull_sel[2] = ({8{pullup_enable_0_reg[4]}} & PPDC_P2_GRP_LOW)
            | ({8{pullup_enable_0_reg[5]}} & PPDC_P2_GRP_HIGH);
        pull_sel[3] = ({8{pullup_enable_0_reg[6]}} & PPDC_P3_GRP_LOW)
            | ({8{pullup_enable_0_reg[7]}} & PPDC_P3_GRP_HIGH);
        pull_sel[4] = ({8{pullup_enable_1_reg[PPDC_PU1_PORT4_PIN3]}} & PPDC_P4_PIN3)
            | ({8{pullup_enable_1_reg[PPDC_PU1_PORT4_UPPER]}} & PPDC_P4_UPPER);
        pull_sel[5] = {8{pullup_enable_1_reg[PPDC_PU1_PORT6_PIN6]}} & PPDC_P6_PIN6;
        drive_sel[0] = ({8{group_drive_strength_0_reg[PPDC_DR0_PORT0_LOW]}} & PPDC_P0_GRP_LOW)
            | ({8{group_drive_strength_0_reg[PPDC_DR0_PORT0_HIGH]}} & PPDC_P0_GRP_HIGH);
        drive_sel[1] = port1_drive_strength_reg;
        drive_sel[2] = port2_drive_strength_reg & PPDC_P2_PINS;
        drive_sel[3] = ({8{group_drive_strength_0_reg[PPDC_DR0_PORT3_LOW]}} & PPDC_P3_GRP_LOW)
            | ({8{group_drive_strength_0_reg[PPDC_DR0_PORT3_HIGH]}} & PPDC_P3_GRP_HIGH);
        drive_sel[4] = ({8{group_drive_strength_1_reg[PPDC_DR1_PORT4_PIN3]}} & PPDC_P4_PIN3)
            | ({8{group_drive_strength_1_reg[PPDC_DR1_PORT4_UPPER]}} & PPDC_P4_UPPER);
        drive_sel[5] = {8{group_drive_strength_1_reg[PPDC_DR1_PORT6_PIN6]}} & PPDC_P6_PIN6;
    end

    // ==========================================================
    // direction gating per port
    for (genvar p = 0; p < NPORT; p++) begin : g_port
        ppdc_pad_gate #(
            .PINS(8)
        ) u_gate (
            .pull_sel(pull_sel[p]),
            .drive_sel(drive_sel[p]),
            .dir_out(dir_in[p]),
            .pull_en(pull_en_next[p]),
            .drive_hi(drive_hi_next[p])
        );
    end

    // ==========================================================
    // registered pad levels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int p = 0; p < NPORT; p++) begin
                pull_en_reg[p] <= 8'h00;
                drive_hi_reg[p] <= 8'h00;
            end
        end else begin
            for (int p = 0; p < NPORT; p++) begin
                pull_en_reg[p] <= pull_en_next[p];
                drive_hi_reg[p] <= drive_hi_next[p];
            end
        end
    end

    assign port0_pull_en = pull_en_reg[0];
    assign port1_pull_en = pull_en_reg[1];
    assign port2_pull_en = pull_en_reg[2];
    assign port3_pull_en = pull_en_reg[3];
    assign port4_pull_en = pull_en_reg[4];
    assign port6_pull_en = pull_en_reg[5];
    assign port0_drive_hi = drive_hi_reg[0];
    assign port1_drive_hi = drive_hi_reg[1];
    assign port2_drive_hi = drive_hi_reg[2];
    assign port3_drive_hi = drive_hi_reg[3];
    assign port4_drive_hi = drive_hi_reg[4];
    assign port6_drive_hi = drive_hi_reg[5];
endmodule : ppdc_top

//--- sim/ppdc_checker.sv
// assertion checker for the pad pull-up and drive control bank
`timescale 1ns/1ns
module ppdc_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] port1_dir,
    input wire logic [7:0] port1_pull_en,
    input wire logic [7:0] port1_drive_hi
);
    // ==========================================================
    // access decode
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic rd_done;
    logic wr_done;
    logic [7:0] wd_q1;
    logic [7:0] wd_q2;
    assign rd_done = psel && penable && pready && !pwrite;
    assign wr_done = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
    // write data kept two edges so it lines up with the pad output flop
    always_ff @(posedge pclk) begin
        wd_q1 <= pwdata[7:0];
        wd_q2 <= wd_q1;
    end
    // ==========================================================
    // properties
    chk_reset_clear: assert property (
        $rose(presetn) |-> (port1_pull_en | port1_drive_hi) == 8'h00)
        else $error("pad enables not clear after reset");
    chk_pull_gated: assert property (
        $stable(port1_dir) [*4] |-> (port1_pull_en & port1_dir) == 8'h00)
        else $error("pull-up on an output pin");
    chk_drive_gated: assert property (
        $stable(port1_dir) [*4] |-> (port1_drive_hi & ~port1_dir) == 8'h00)
        else $error("high drive on an input pin");
    chk_gd0_read: assert property (
        rd_done && paddr == 12'h7C8 |-> prdata[5:2] == 4'h0)
        else $error("unimplemented group drive bits read nonzero");
    chk_gd1_read: assert property (
        rd_done && paddr == 12'h7CC |-> prdata[7:6] == 2'h0 && !prdata[2])
        else $error("unimplemented drive bits read nonzero");
    chk_drive_write: assert property (
        $stable(port1_dir) [*4] ##0 (wr_done && paddr == 12'h7C0 && port1_dir == 8'hFF)
        |-> ##2 port1_drive_hi == wd_q2)
        else $error("port 1 drive not taken from write");
    chk_pull_write: assert property (
        $stable(port1_dir) [*4] ##0 (wr_done && paddr == 12'h780 && port1_dir == 8'h00)
        |-> ##2 port1_pull_en == {{4{wd_q2[3]}}, {4{wd_q2[2]}}})
        else $error("port 1 pull-up not taken from write");
    chk_quiet_static: assert property (
        (!pready && $stable(port1_dir)) [*5] |-> $stable(port1_pull_en) && $stable(port1_drive_hi))
        else $error("pad enable moved without a cause");
    cover property (wr_done && paddr == 12'h780);
    cover property (rd_done && paddr == 12'h7C8);
    cover property (pready && pslverr);
endmodule : ppdc_checker

bind ppdc_top ppdc_checker i_ppdc_checker (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .port1_dir, .port1_pull_en, .port1_drive_hi);

//--- sim/ppdc_pad_model.sv
// pad cell and direction model on the pin side of the bank
`timescale 1ns/1ns
module ppdc_pad_model (
    input wire logic pclk,
    input wire logic [7:0] dir_word,
    input wire logic [7:0] port1_pull_en,
    input wire logic [7:0] port1_drive_hi,
    output logic [7:0] dir_q,
    output logic clash
);
    // ==========================================================
    // direction latch and pad conflict watch
    int settle = 0;
    initial begin
        dir_q = 8'h00;
        clash = 1'b0;
    end
    // pads judged only after the bank's three-edge direction path settles
    always @(posedge pclk) begin
        dir_q <= dir_word;
        settle <= (dir_word != dir_q) ? 0 : settle + 1;
        if (settle > 4 && (port1_pull_en & dir_q) != 8'h00) clash <= 1'b1;
        if (settle > 4 && (port1_drive_hi & ~dir_q) != 8'h00) clash <= 1'b1;
    end
endmodule : ppdc_pad_model

//--- sim/testbench.sv
// self-checking bench for the pad pull-up and drive control bank
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin fails++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module testbench;
    logic pclk;
    logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    logic [7:0] dir_word = 8'h00;
    logic [7:0] pe0 = 8'h00, pe1 = 8'h00, p1 = 8'h00, p2 = 8'h00, g0 = 8'h00, g1 = 8'h00;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, clash;
    logic [7:0] dir_q;
    wire [5:0][7:0] pull;
    wire [5:0][7:0] drv;
    int fails = 0, n_checks = 0, cyc = 0;
    // ==========================================================
    // design and pad model; one direction word feeds every port
    ppdc_top i_ppdc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .port0_dir(dir_q), .port1_dir(dir_q), .port2_dir(dir_q),
        .port3_dir(dir_q), .port4_dir(dir_q), .port6_dir(dir_q), .port0_pull_en(pull[0]),
        .port1_pull_en(pull[1]), .port2_pull_en(pull[2]), .port3_pull_en(pull[3]),
        .port4_pull_en(pull[4]), .port6_pull_en(pull[5]), .port0_drive_hi(drv[0]),
        .port1_drive_hi(drv[1]), .port2_drive_hi(drv[2]), .port3_drive_hi(drv[3]),
        .port4_drive_hi(drv[4]), .port6_drive_hi(drv[5]));
    ppdc_pad_model i_ppdc_pad_model (.pclk, .dir_word, .port1_pull_en(pull[1]),
        .port1_drive_hi(drv[1]), .dir_q, .clash);
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // ceiling far above the roughly 120 cycles the scenarios need
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            results();
        end
    end
    // ==========================================================
    // helpers
    task automatic results();
        if (fails == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                       input logic [3:0] s);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // answer and read data taken at the rising edge that sees pready high
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    function automatic logic [7:0] spread(int p, logic [7:0] a, logic [7:0] b);
        case (p)
            0: return (a[0] ? 8'h0E : 8'h00) | (a[1] ? 8'hD0 : 8'h00);
            1: return (a[2] ? 8'h0F : 8'h00) | (a[3] ? 8'hF0 : 8'h00);
            2: return (a[4] ? 8'h0F : 8'h00) | (a[5] ? 8'h30 : 8'h00);
            3: return (a[6] ? 8'h0A : 8'h00) | (a[7] ? 8'hB0 : 8'h00);
            4: return (b[0] ? 8'h08 : 8'h00) | (b[1] ? 8'hF0 : 8'h00);
            default: return b[5] ? 8'h40 : 8'h00;
        endcase
    endfunction : spread
    task automatic check_pads();
        logic [7:0] dx;
        @(negedge pclk);
        for (int p = 0; p < 6; p++) begin
            dx = p == 1 ? p1 : p == 2 ? p2 & 8'h3F : spread(p, g0, g1);
            `CHK("pull_en", spread(p, pe0, pe1) & ~dir_word, pull[p])
            `CHK("drive_hi", dx & dir_word, drv[p])
        end
        @(posedge pclk);
    endtask : check_pads
    // ==========================================================
    // scenarios
    task automatic reset_values();
        logic [11:0] a [6] = '{12'h780, 12'h784, 12'h7C0, 12'h7C4, 12'h7C8, 12'h7CC};
        {pe0, pe1, p1, p2, g0, g1} = 48'h0000_0000_0000;
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, a[i], 8'h00, 4'hF);
            `CHK("reset read", 32'h0000_0000, rd & (i == 1 ? 32'h0000_003F : 32'hFFFF_FFFF))
        end
        check_pads();
    endtask : reset_values
    // reset again with registers and pads set, so clearing is really seen
    task automatic mid_reset();
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        reset_values();
    endtask : mid_reset
    task automatic pull_ups();
        pe0 = 8'hA5;
        pe1 = 8'h23;
        apb(1'b1, 12'h780, pe0, 4'hF);
        apb(1'b1, 12'h784, pe1, 4'hF);
        apb(1'b0, 12'h784, 8'h00, 4'hF);
        `CHK("pullup_enable_1", 32'h0000_0023, rd & 32'h0000_003F)
        check_pads();
        dir_word <= 8'h3C;
        repeat (5) @(posedge pclk);
        check_pads();
    endtask : pull_ups
    task automatic drive_strength();
        dir_word <= 8'hFF;
        repeat (5) @(posedge pclk);
        p1 = 8'h96;
        p2 = 8'h2D;
        g0 = 8'hC3;
        g1 = 8'h23;
        apb(1'b1, 12'h7C0, p1, 4'hF);
        apb(1'b1, 12'h7C4, p2, 4'hF);
        apb(1'b1, 12'h7C8, 8'hFF, 4'hF);
        apb(1'b1, 12'h7CC, 8'hC7, 4'hF);
        apb(1'b0, 12'h7C8, 8'h00, 4'hF);
        `CHK("group_drive_strength_0", 32'h0000_00C3, rd)
        apb(1'b0, 12'h7CC, 8'h00, 4'hF);
        `CHK("group_drive_strength_1", 32'h0000_0003, rd & 32'h0000_0007)
        apb(1'b1, 12'h7CC, g1, 4'hF);
        apb(1'b0, 12'h7C4, 8'h00, 4'hF);
        `CHK("port2_drive_strength", 32'h0000_002D, rd)
        check_pads();
        dir_word <= 8'h00;
        repeat (5) @(posedge pclk);
        check_pads();
    endtask : drive_strength
    task automatic refusals();
        apb(1'b1, 12'h7D0, 8'h55, 4'hF);
        `CHK("unmapped error", 1'b1, er)
        apb(1'b1, 12'h781, 8'h00, 4'hF);
        `CHK("misaligned error", 1'b1, er)
        apb(1'b0, 12'h7D0, 8'h00, 4'hF);
        `CHK("unmapped read", 32'h0000_0000, rd)
        apb(1'b1, 12'h7C0, 8'h00, 4'h0);
        apb(1'b0, 12'h780, 8'h00, 4'hF);
        `CHK("pullup_enable_0", 32'h0000_00A5, rd)
        `CHK("pslverr", 1'b0, er)
        apb(1'b0, 12'h7C0, 8'h00, 4'hF);
        `CHK("port1_drive_strength", 32'h0000_0096, rd)
        check_pads();
        `CHK("pad clash", 1'b0, clash)
    endtask : refusals
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        reset_values();
        pull_ups();
        drive_strength();
        refusals();
        mid_reset();
        results();
    end
endmodule : testbench
